// ==== cct_assertions.sv ====
/* port checker for the capture/compare timer.
   assumes the bind at the foot; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module cct_assertions (
    input logic       i_clk,
    input logic       i_rstn,
    input logic [7:0] i_addr,
    input logic [7:0] i_wdata,
    input logic       i_wr,
    input logic       i_rd,
    input logic [7:0] o_rdata,
    input logic       i_capture_input_pin,
    input logic       o_compare_output_pin,
    input logic       i_stop,
    input logic       i_wait,
    input logic       o_irq,
    input logic       o_wake
);
    logic lvl;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // shadow of the level bit, so every pin move can be judged
    always @(posedge i_clk) begin
        if (!i_rstn) lvl <= 1'h0;
        else if (i_wr && i_addr == 8'h12) lvl <= i_wdata[0];
    end
    a_wake_is_irq: assert property (o_wake == o_irq) else $error("wake differs from irq");
    a_reset_quiet: assert property (disable iff (1'h0)
        !i_rstn |=> !o_irq && !o_compare_output_pin) else $error("irq or pin set after reset");
    a_ctrl_readback: assert property (
        i_wr && i_addr == 8'h12 ##1 i_rd && i_addr == 8'h12 |=>
        o_rdata[7:5] == $past(i_wdata[7:5], 2) && o_rdata[1:0] == $past(i_wdata[1:0], 2))
        else $error("control readback wrong");
    a_pin_level: assert property ($changed(o_compare_output_pin) |-> o_compare_output_pin == $past(lvl))
        else $error("pin moved to wrong level");
    a_ovf_clear: assert property (i_rd && i_addr == 8'h13 ##1 i_rd && i_addr == 8'h19 && o_rdata[5]
        ##1 i_rd && i_addr == 8'h13 |=> !o_rdata[5]) else $error("overflow flag kept");
    a_cap_clear: assert property (i_rd && i_addr == 8'h13 ##1 i_rd && i_addr == 8'h15 && o_rdata[7]
        ##1 i_rd && i_addr == 8'h13 |=> !o_rdata[7]) else $error("capture flag kept");
    a_cmp_clear: assert property (i_rd && i_addr == 8'h13 ##1 i_rd && i_addr == 8'h17 && o_rdata[6]
        ##1 i_rd && i_addr == 8'h13 |=> !o_rdata[6]) else $error("compare flag kept");
    a_stop_hold: assert property (i_stop && i_rd && i_addr == 8'h1B ##1 i_stop && i_rd && i_addr == 8'h1B
        |=> o_rdata == $past(o_rdata)) else $error("count moved in stop");
    c_irq: cover property (o_irq);
    c_pin_rise: cover property ($rose(o_compare_output_pin));
    c_stop_read: cover property (i_stop && i_rd);
endmodule
bind cct_timer cct_assertions u_chk (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_capture_input_pin, .o_compare_output_pin, .i_stop, .i_wait, .o_irq, .o_wake);

// ==== cct_pin_model.sv ====
/* partner on the timer pins: source for the capture input, load on the compare output.
   assumes the bench picks the source level; the load counts rising moves. */
`timescale 1ns/1ps
module cct_pin_model (
    input  logic       i_clk,
    input  logic       i_level,
    input  logic       i_load,
    output logic       o_source = 1'h0,
    output logic [7:0] o_rises = 8'h00
);
    logic last = 1'h0;
    // registered source, so edges land only on the clock edge, where the timer still samples the old level
    always @(posedge i_clk) begin
        o_source <= i_level;
        last <= i_load;
        if (i_load && !last) o_rises <= o_rises + 8'h01;
    end
endmodule

// ==== cct_regs.vh ====
/*
 * register map, field positions and timing counts of the capture/compare timer.
 * assumes byte-wide registers on a plain strobe bus with 8-bit addresses.
 */
`ifndef CCT_REGS_VH
`define CCT_REGS_VH

`define CCT_ADDR_CTRL       8'h12
`define CCT_ADDR_FLAGS      8'h13
`define CCT_ADDR_CAP_HI     8'h14
`define CCT_ADDR_CAP_LO     8'h15
`define CCT_ADDR_CMP_HI     8'h16
`define CCT_ADDR_CMP_LO     8'h17
`define CCT_ADDR_CNT_HI     8'h18
`define CCT_ADDR_CNT_LO     8'h19
`define CCT_ADDR_ALT_HI     8'h1A
`define CCT_ADDR_ALT_LO     8'h1B

`define CCT_BIT_CAP_IE      7
`define CCT_BIT_CMP_IE      6
`define CCT_BIT_OVF_IE      5
`define CCT_BIT_EDGE        1
`define CCT_BIT_LEVEL       0

`define CCT_BIT_CAP_F       7
`define CCT_BIT_CMP_F       6
`define CCT_BIT_OVF_F       5

`define CCT_PRESCALE        2'h3
`define CCT_CNT_STOP_RESET  16'hFFFC
`define CCT_CMP_RESET       16'hFFFF

`endif

// ==== cct_timer.v ====
/*
 * 16-bit free-running capture/compare timer with its byte-wide register set.
 * assumes a single clock, synchronous capture pin, and stop/wait levels and the
 * stop-exit cause supplied by the surrounding core.
 */
// Implementation choice: the address-and-strobe port.
// Behaviour
// - counter advances every fourth clock, prescaled
// - compare evaluated once every fourth clock
// - capture irq enable rw, reset clears
// - compare irq enable rw, reset clears
// - overflow irq enable rw, reset clears
// - edge select rising/falling, reset keeps
// - match drives compare pin to level
// - capture flag set; status then low read clears
// - compare flag set; status then low access clears
// - overflow flag on wrap; status then low clears
// - reset leaves status flags alone
// - counter high read freezes low view
// - alternate pair latches, never clears overflow
// - capture edge copies count; writes ignored
// - capture high read blocks all but stop-release capture until low
// - compare high write suspends matching until low
// - compare low access after status clears flag
// - counts in wait; enabled irq wakes
// - stop halts counter; reset exit loads FFFC
// - stop edge arms capture; reset discards
`timescale 1ns/1ps
`include "cct_regs.vh"

module cct_timer #(
    parameter [1:0]  PRESCALE_LAST = `CCT_PRESCALE,
    parameter [15:0] STOP_RESET    = `CCT_CNT_STOP_RESET,
    parameter [15:0] CMP_RESET     = `CCT_CMP_RESET
) (
    input  wire       i_clk,
    input  wire       i_rstn,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    input  wire       i_capture_input_pin,
    output reg        o_compare_output_pin,
    input  wire       i_stop,
    input  wire       i_wait,
    output wire       o_irq,
    output wire       o_wake
);

    reg  [1:0]  prescale;
    reg  [15:0] count;
    reg  [15:0] capture;
    reg  [15:0] compare;
    reg  [7:0]  cnt_lo_hold;
    reg  [7:0]  alt_lo_hold;
    reg         cnt_frozen;
    reg         alt_frozen;
    reg         cap_blocked;
    reg         cmp_suspended;
    reg         capture_irq_enable;
    reg         compare_irq_enable;
    reg         overflow_irq_enable;
    reg         capture_edge_select;
    reg         compare_output_level;
    reg         capture_flag;
    reg         compare_flag;
    reg         overflow_flag;
    reg         cap_armed_f;
    reg         cmp_armed_f;
    reg         ovf_armed_f;
    reg         pin_q;
    reg         stop_q;
    reg         stop_pend;
    reg  [15:0] stop_data;

    wire        tick;
    wire        edge_seen;
    wire        cap_take;
    wire        cmp_hit;
    wire        wrap;
    wire [7:0]  ctrl_v;
    wire [7:0]  flags_v;
    reg  [7:0]  next_rdata;

    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    // register strobes, decoded once and shared by several processes
    wire        wr_ctrl;
    wire        wr_cmp_hi;
    wire        wr_cmp_lo;
    wire        rd_flags;
    wire        rd_cap_hi;
    wire        rd_cap_lo;
    wire        acc_cmp_lo;
    wire        rd_cnt_hi;
    wire        rd_cnt_lo;
    wire        rd_alt_hi;
    wire        rd_alt_lo;
    wire        stop_edge;
    wire        stop_release;

    assign wr_ctrl      = i_wr && is_addr(i_addr, `CCT_ADDR_CTRL);
    assign wr_cmp_hi    = i_wr && is_addr(i_addr, `CCT_ADDR_CMP_HI);
    assign wr_cmp_lo    = i_wr && is_addr(i_addr, `CCT_ADDR_CMP_LO);
    assign rd_flags     = i_rd && is_addr(i_addr, `CCT_ADDR_FLAGS);
    assign rd_cap_hi    = i_rd && is_addr(i_addr, `CCT_ADDR_CAP_HI);
    assign rd_cap_lo    = i_rd && is_addr(i_addr, `CCT_ADDR_CAP_LO);
    assign acc_cmp_lo   = (i_rd || i_wr) && is_addr(i_addr, `CCT_ADDR_CMP_LO);
    assign rd_cnt_hi    = i_rd && is_addr(i_addr, `CCT_ADDR_CNT_HI);
    assign rd_cnt_lo    = i_rd && is_addr(i_addr, `CCT_ADDR_CNT_LO);
    assign rd_alt_hi    = i_rd && is_addr(i_addr, `CCT_ADDR_ALT_HI);
    assign rd_alt_lo    = i_rd && is_addr(i_addr, `CCT_ADDR_ALT_LO);
    // only the first edge inside stop is remembered
    assign stop_edge    = i_stop && edge_seen && !stop_pend;
    // stop left without reset: the remembered edge becomes a capture
    assign stop_release = !i_stop && stop_pend;

    // prescaler only runs outside stop
    assign tick = (prescale == PRESCALE_LAST) && !i_stop;
    assign wrap = tick && (count == 16'hFFFF);
    assign cmp_hit = tick && !cmp_suspended && (count == compare);
    assign edge_seen = capture_edge_select ? (i_capture_input_pin && !pin_q)
                                           : (!i_capture_input_pin && pin_q);
    assign cap_take = edge_seen && !cap_blocked && !i_stop;

    assign ctrl_v = {capture_irq_enable, compare_irq_enable, overflow_irq_enable,
                     3'h0, capture_edge_select, compare_output_level};
    assign flags_v = {capture_flag, compare_flag, overflow_flag, 5'h00};

    assign o_irq = (capture_flag && capture_irq_enable) ||
                   (compare_flag && compare_irq_enable) ||
                   (overflow_flag && overflow_irq_enable);
    // wait does not gate the request, so it also wakes the core
    assign o_wake = o_irq;

    // previous pin level for the edge detector
    always @(posedge i_clk) begin
        pin_q <= i_capture_input_pin;
    end

    // stop one cycle back tells a reset that ends stop from a plain one
    always @(posedge i_clk) begin
        stop_q <= i_stop;
    end

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            prescale <= 2'h0;
        end else if (i_stop) begin
            prescale <= 2'h0;
        end else begin
            prescale <= prescale + 2'h1;
        end
    end

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            if (stop_q) begin
                count <= STOP_RESET;
            end
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // control bits; edge select is untouched by reset
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            capture_irq_enable   <= 1'b0;
            compare_irq_enable   <= 1'b0;
            overflow_irq_enable  <= 1'b0;
            compare_output_level <= 1'b0;
        end else if (wr_ctrl) begin
            capture_irq_enable   <= i_wdata[`CCT_BIT_CAP_IE];
            compare_irq_enable   <= i_wdata[`CCT_BIT_CMP_IE];
            overflow_irq_enable  <= i_wdata[`CCT_BIT_OVF_IE];
            compare_output_level <= i_wdata[`CCT_BIT_LEVEL];
        end
    end

    always @(posedge i_clk) begin
        if (i_rstn && wr_ctrl) begin
            capture_edge_select <= i_wdata[`CCT_BIT_EDGE];
        end
    end

    // pin keeps its level between matches; a level change alone moves nothing
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            o_compare_output_pin <= 1'b0;
        end else if (cmp_hit) begin
            o_compare_output_pin <= compare_output_level;
        end
    end

    // compare register pair and high-write suspend
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            compare       <= CMP_RESET;
            cmp_suspended <= 1'b0;
        end else if (wr_cmp_hi) begin
            compare[15:8] <= i_wdata;
            cmp_suspended <= 1'b1;
        end else if (wr_cmp_lo) begin
            compare[7:0]  <= i_wdata;
            cmp_suspended <= 1'b0;
        end
    end

    // high read blocks pin-edge capture, so only a stop release can tear the byte pair
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            cap_blocked <= 1'b0;
        end else if (rd_cap_hi) begin
            cap_blocked <= 1'b1;
        end else if (rd_cap_lo) begin
            cap_blocked <= 1'b0;
        end
    end

    // reset throws a remembered stop edge away
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            stop_pend <= 1'b0;
        end else if (stop_edge) begin
            stop_pend <= 1'b1;
        end else if (stop_release) begin
            stop_pend <= 1'b0;
        end
    end

    always @(posedge i_clk) begin
        if (i_rstn && stop_edge) begin
            stop_data <= count;
        end
    end

    always @(posedge i_clk) begin
        if (i_rstn) begin
            if (stop_release) begin
                capture <= stop_data;
            end else if (cap_take) begin
                capture <= count;
            end
        end
    end

    // status read arms a clear; the low-byte access uses the arm up either way
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            cap_armed_f <= 1'b0;
            cmp_armed_f <= 1'b0;
            ovf_armed_f <= 1'b0;
        end else if (rd_flags) begin
            cap_armed_f <= capture_flag;
            cmp_armed_f <= compare_flag;
            ovf_armed_f <= overflow_flag;
        end else begin
            if (rd_cap_lo) begin
                cap_armed_f <= 1'b0;
            end
            if (acc_cmp_lo) begin
                cmp_armed_f <= 1'b0;
            end
            if (rd_cnt_lo) begin
                ovf_armed_f <= 1'b0;
            end
        end
    end

    // flags: reset leaves them, and a new event wins over a clear
    always @(posedge i_clk) begin
        if (i_rstn) begin
            if (cap_take || stop_release) begin
                capture_flag <= 1'b1;
            end else if (cap_armed_f && rd_cap_lo) begin
                capture_flag <= 1'b0;
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_rstn) begin
            if (cmp_hit) begin
                compare_flag <= 1'b1;
            end else if (cmp_armed_f && acc_cmp_lo) begin
                compare_flag <= 1'b0;
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_rstn) begin
            if (wrap) begin
                overflow_flag <= 1'b1;
            end else if (ovf_armed_f && rd_cnt_lo) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // counter low-byte latches; each pair freezes on its own high read
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_frozen <= 1'b0;
        end else if (rd_cnt_hi) begin
            cnt_frozen <= 1'b1;
        end else if (rd_cnt_lo) begin
            cnt_frozen <= 1'b0;
        end
    end

    always @(posedge i_clk) begin
        if (i_rstn && rd_cnt_hi) begin
            cnt_lo_hold <= count[7:0];
        end
    end

    // the alternate pair never touches the overflow arm
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            alt_frozen <= 1'b0;
        end else if (rd_alt_hi) begin
            alt_frozen <= 1'b1;
        end else if (rd_alt_lo) begin
            alt_frozen <= 1'b0;
        end
    end

    always @(posedge i_clk) begin
        if (i_rstn && rd_alt_hi) begin
            alt_lo_hold <= count[7:0];
        end
    end

    // read mux; counter/capture pairs ignore writes, unmapped reads zero
    always @* begin
        next_rdata = 8'h00;
        case (i_addr)
            `CCT_ADDR_CTRL:   next_rdata = ctrl_v;
            `CCT_ADDR_FLAGS:  next_rdata = flags_v;
            `CCT_ADDR_CAP_HI: next_rdata = capture[15:8];
            `CCT_ADDR_CAP_LO: next_rdata = capture[7:0];
            `CCT_ADDR_CMP_HI: next_rdata = compare[15:8];
            `CCT_ADDR_CMP_LO: next_rdata = compare[7:0];
            `CCT_ADDR_CNT_HI: next_rdata = count[15:8];
            `CCT_ADDR_CNT_LO: next_rdata = cnt_frozen ? cnt_lo_hold : count[7:0];
            `CCT_ADDR_ALT_HI: next_rdata = count[15:8];
            `CCT_ADDR_ALT_LO: next_rdata = alt_frozen ? alt_lo_hold : count[7:0];
            default:          next_rdata = 8'h00;
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule

// ==== test_capture_compare_timer.sv ====
/* self-checking bench for the capture/compare timer.
   assumes the pin model beside it and the checker bound to the timer. */
`timescale 1ns/1ps
module test_capture_compare_timer;
    logic        i_clk = 1'h0, i_rstn = 1'h0, i_wr = 1'h0, i_rd = 1'h0, i_stop = 1'h1, i_wait = 1'h0, lvl = 1'h0;
    logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, d0, d1, d2, v0;
    logic [16:0] s = 17'h1_2059;
    wire  [7:0]  o_rdata, rises;
    wire         i_capture_input_pin, o_compare_output_pin, o_irq, o_wake;
    int          num_errors = 0, checks = 0, k;

    cct_timer u_dut (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_capture_input_pin,
        .o_compare_output_pin, .i_stop, .i_wait, .o_irq, .o_wake);
    cct_pin_model u_pins (.i_clk, .i_level(lvl), .i_load(o_compare_output_pin),
        .o_source(i_capture_input_pin), .o_rises(rises));

    always #4 i_clk = ~i_clk;

    function automatic [16:0] lfsr(input [16:0] x);
        lfsr = {x[15:0], x[16] ^ x[13]};
    endfunction
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic close_out;
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_clk);
        i_wr <= 1'h0;
    endtask
    // three back-to-back reads; each answer is sampled settled, just after its launch edge
    task automatic rd3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_clk);
        i_addr <= b;
        #1 d0 = o_rdata;
        @(posedge i_clk);
        i_addr <= c;
        #1 d1 = o_rdata;
        @(posedge i_clk);
        i_rd <= 1'h0;
        #1 d2 = o_rdata;
        @(posedge i_clk);
        #1;
    endtask
    task automatic rst(input logic st);
        i_stop <= st;
        i_rstn <= 1'h0;
        tick(10);
        i_rstn <= 1'h1;
    endtask

    initial begin
        tick(20000);
        num_errors++;
        close_out;
    end

    initial begin
        @(posedge i_clk);
        rst(1'h1);
        wr(8'h12, 8'h02);
        rd3(8'h12, 8'h1B, 8'h1B);
        chk("ctrl", d0, 8'h02);
        chk("count lo", d2, 8'hFC);
        lvl <= 1'h1;
        tick(4);
        i_stop <= 1'h0;
        tick(8);
        rd3(8'h14, 8'h00, 8'h00);
        chk("cap hi", d0, 8'hFF);
        rd3(8'h13, 8'h15, 8'h13);
        chk("cap flag", d0 & 8'h80, 8'h80);
        chk("cap lo", d1, 8'hFC);
        chk("cap clr", d2 & 8'h80, 8'h00);
        rd3(8'h14, 8'h00, 8'h00);
        lvl <= 1'h0;
        tick(3);
        lvl <= 1'h1;
        tick(3);
        rd3(8'h15, 8'h00, 8'h00);
        chk("cap blocked", d0, 8'hFC);
        rd3(8'h13, 8'h00, 8'h00);
        chk("ovf", d0 & 8'h20, 8'h20);
        wr(8'h12, 8'h22);
        rd3(8'h12, 8'h00, 8'h00);
        chk("ctrl ie", d0, 8'h22);
        chk("irq", {7'h00, o_irq}, 8'h01);
        chk("wake", {7'h00, o_wake}, 8'h01);
        rst(1'h0);
        rd3(8'h13, 8'h12, 8'h00);
        chk("ovf kept", d0 & 8'h20, 8'h20);
        chk("ctrl rst", d1, 8'h02);
        chk("irq off", {7'h00, o_irq}, 8'h00);
        chk("wake off", {7'h00, o_wake}, 8'h00);
        rd3(8'h13, 8'h19, 8'h13);
        chk("ovf clr", d2 & 8'h20, 8'h00);
        rst(1'h1);
        i_stop <= 1'h0;
        tick(24);
        rd3(8'h13, 8'h1B, 8'h13);
        chk("wrap", d0 & 8'h20, 8'h20);
        chk("alt ovf", d2 & 8'h20, 8'h20);
        rst(1'h1);
        wr(8'h12, 8'h03);
        tick(1);
        wr(8'h16, 8'h00);
        rd3(8'h13, 8'h00, 8'h00);
        wr(8'h17, 8'h02);
        i_stop <= 1'h0;
        tick(40);
        chk("pin", {7'h00, o_compare_output_pin}, 8'h01);
        rd3(8'h13, 8'h17, 8'h13);
        chk("cmp flag", d0 & 8'h40, 8'h40);
        chk("cmp clr", d2 & 8'h40, 8'h00);
        rst(1'h1);
        wr(8'h12, 8'h03);
        tick(1);
        wr(8'h16, 8'h00);
        i_stop <= 1'h0;
        tick(40);
        rd3(8'h13, 8'h00, 8'h00);
        chk("cmp held", d0 & 8'h40, 8'h00);
        chk("pin held", {7'h00, o_compare_output_pin}, 8'h00);
        wr(8'h17, 8'h10);
        tick(80);
        chk("pin match", {7'h00, o_compare_output_pin}, 8'h01);
        chk("rises", rises, 8'h02);
        for (int i = 0; i < 6; i++) begin
            s = lfsr(s);
            k = s[10:8] + 1;
            i_wait <= s[12];
            wr(8'h12, s[7:0]);
            rd3(8'h12, 8'h1B, 8'h00);
            chk("ctrl rand", d0, s[7:0] & 8'hE3);
            v0 = d1;
            tick(4 * k - 3);
            rd3(8'h1B, 8'h00, 8'h00);
            chk("step", d0, v0 + k[7:0]);
        end
        close_out;
    end
endmodule
